// file: jtd_pkg.sv
// What this block does
// - sixteen-state tap machine, steps on tck rise
// - power-on reset lands in test-logic-reset
// - all scan registers shift lsb first
// - tap state picks ir or dr, instruction picks the dr path
// - controller walks idle to shift-ir: 1100
// - four-bit instruction, tms high on last
// - ir capture value 0x01 shifts out
// - instruction changes in update-ir; test-logic-reset loads bypass
// - controller returns to idle with 110
// - controller walks idle to shift-dr: 100
// - dr shift, tms high on last bit
// - latched dr output loads in update-dr
// - five tms-high clocks force reset state
// - some instructions act during run-test/idle
// - no test-reset pin on the port
// - fuse unprogrammed: pins plain, tap reset
// - fuse set, disable clear: pullups, enabled
// - debug only with fuse and no locks
// - debugger watches and may pull reset
// - debug access through cpu scan chain
// - break unit: flow, step, four points
// - break points form one of five sets
package jtd_pkg;
	// ==========================================================
	// tap states
	typedef enum logic [15:0] {
		JTD_TLR = 16'h0001, JTD_RTI = 16'h0002, JTD_SDS = 16'h0004,
		JTD_CDR = 16'h0008, JTD_SDR = 16'h0010, JTD_E1D = 16'h0020,
		JTD_PDR = 16'h0040, JTD_E2D = 16'h0080, JTD_UDR = 16'h0100,
		JTD_SIS = 16'h0200, JTD_CIR = 16'h0400, JTD_SIR = 16'h0800,
		JTD_E1I = 16'h1000, JTD_PIR = 16'h2000, JTD_E2I = 16'h4000,
		JTD_UIR = 16'h8000
	} jtd_state_e;
	// ==========================================================
	// widths, capture values and instructions
	localparam int         IR_W       = 4;
	localparam int         DR_W       = 8;
	localparam logic [3:0] IR_CAPTURE = 4'h1;
	localparam logic [3:0] IR_BYPASS  = 4'hF;
	localparam logic [3:0] IR_DATA    = 4'h4;  // general data register
	localparam logic [3:0] IR_BRKCFG  = 4'h8;  // break-point config
	localparam logic [3:0] IR_RESET   = 4'hC;  // system reset request
	localparam logic [3:0] IR_IDLE_DEFAULT = IR_BYPASS;
	localparam int         BRK_MODES  = 5;
	localparam int         RESET_TLR_CLOCKS = 5;
	// divider for the controller's tck: 8 -> 160 ns at 50 MHz
	localparam int         TCK_HALF   = 4;
	localparam logic [3:0] CMD_IR     = 4'h1;
	localparam logic [3:0] CMD_DR     = 4'h2;
	localparam logic [3:0] CMD_RESET  = 4'h3;
	localparam logic [3:0] CMD_IDLE   = 4'h4;
	// controller register offsets
	localparam logic [3:0] ADR_CMD    = 4'h0;
	localparam logic [3:0] ADR_DATA   = 4'h1;
	localparam logic [3:0] ADR_RESULT = 4'h2;
	localparam logic [3:0] ADR_STATUS = 4'h3;
	localparam logic [3:0] ADR_LEN    = 4'h4;
endpackage : jtd_pkg

// file: jtd_if.sv
`timescale 1ns/1ps
// test port pins; reset line is open drain, wired here
interface jtd_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe;
	logic rst_pull_dev;  // device side drives low (oe)
	logic rst_pull_dbg;  // debugger drives low (oe)
	logic rst_line;
	assign rst_line = !(rst_pull_dev || rst_pull_dbg);
	modport device (input tck, input tms, input tdi, output tdo,
		output tdo_oe, output rst_pull_dev, input rst_line);
	modport host (output tck, output tms, output tdi, input tdo,
		input tdo_oe, output rst_pull_dbg, input rst_line);
endinterface : jtd_if

// file: jtd_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser, one per bit
module jtd_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta;
	// ==========================================================
	// meta feeds only the second stage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end
endmodule : jtd_sync

// file: jtd_device.sv
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/1ps
// device end: tap, ir, data registers, enable gates, break config
module jtd_device (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	jtd_if.device           port,
	input  wire logic       test_port_enable_fuse_i,
	input  wire logic       test_port_disable_bit_i,
	input  wire logic       debug_system_enable_fuse_i,
	input  wire logic       security_lock_bit_one_i,
	input  wire logic       security_lock_bit_two_i,
	input  wire logic [7:0] dr_capture_i,
	output logic            tap_enabled_o,
	output logic            pin_pullup_o,
	output logic            debug_enabled_o,
	output logic [3:0]      instr_o,
	output logic [7:0]      dr_update_o,
	output logic [2:0]      brk_mode_o,
	output logic            idle_action_o,
	output logic            sys_reset_seen_o
);
	// ==========================================================
	// pin sampling
	logic [3:0] pins;
	jtd_sync #(.W(4)) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({port.tck, port.tms, port.tdi, port.rst_line}),
		.q_o     (pins)
	);
	logic tck_q;
	logic rise;
	logic fall;
	logic en;
	assign en = test_port_enable_fuse_i && !test_port_disable_bit_i;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) tck_q <= 1'b0;
		else tck_q <= pins[3];
	end
	assign rise = pins[3] && !tck_q;
	assign fall = !pins[3] && tck_q;
	// ==========================================================
	// tap state machine
	jtd_pkg::jtd_state_e state;
	jtd_pkg::jtd_state_e next_state;
	logic tms;
	assign tms = pins[2];
	always_comb begin
		next_state = state;
		case (state)
			jtd_pkg::JTD_TLR: next_state = tms ? jtd_pkg::JTD_TLR : jtd_pkg::JTD_RTI;
			jtd_pkg::JTD_RTI: next_state = tms ? jtd_pkg::JTD_SDS : jtd_pkg::JTD_RTI;
			jtd_pkg::JTD_SDS: next_state = tms ? jtd_pkg::JTD_SIS : jtd_pkg::JTD_CDR;
			jtd_pkg::JTD_CDR: next_state = tms ? jtd_pkg::JTD_E1D : jtd_pkg::JTD_SDR;
			jtd_pkg::JTD_SDR: next_state = tms ? jtd_pkg::JTD_E1D : jtd_pkg::JTD_SDR;
			jtd_pkg::JTD_E1D: next_state = tms ? jtd_pkg::JTD_UDR : jtd_pkg::JTD_PDR;
			jtd_pkg::JTD_PDR: next_state = tms ? jtd_pkg::JTD_E2D : jtd_pkg::JTD_PDR;
			jtd_pkg::JTD_E2D: next_state = tms ? jtd_pkg::JTD_UDR : jtd_pkg::JTD_SDR;
			jtd_pkg::JTD_UDR: next_state = tms ? jtd_pkg::JTD_SDS : jtd_pkg::JTD_RTI;
			jtd_pkg::JTD_SIS: next_state = tms ? jtd_pkg::JTD_TLR : jtd_pkg::JTD_CIR;
			jtd_pkg::JTD_CIR: next_state = tms ? jtd_pkg::JTD_E1I : jtd_pkg::JTD_SIR;
			jtd_pkg::JTD_SIR: next_state = tms ? jtd_pkg::JTD_E1I : jtd_pkg::JTD_SIR;
			jtd_pkg::JTD_E1I: next_state = tms ? jtd_pkg::JTD_UIR : jtd_pkg::JTD_PIR;
			jtd_pkg::JTD_PIR: next_state = tms ? jtd_pkg::JTD_E2I : jtd_pkg::JTD_PIR;
			jtd_pkg::JTD_E2I: next_state = tms ? jtd_pkg::JTD_UIR : jtd_pkg::JTD_SIR;
			jtd_pkg::JTD_UIR: next_state = tms ? jtd_pkg::JTD_SDS : jtd_pkg::JTD_RTI;
			default:          next_state = jtd_pkg::JTD_TLR;
		endcase
	end
	// reset paths
	// no trst pin: power-on, tms walk or disabled port only
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) state <= jtd_pkg::JTD_TLR;
		else if (!en) state <= jtd_pkg::JTD_TLR;
		else if (rise) state <= next_state;
	end
	// five ones reach reset
	// the table itself returns to reset after five tms-high rises
	// ==========================================================
	// shift registers, lsb first
	logic [3:0] ir_sh;
	logic [7:0] dr_sh;
	logic       byp;
	logic       tdi;
	assign tdi = pins[1];
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) ir_sh <= 4'h0;
		else if (rise && state == jtd_pkg::JTD_CIR) ir_sh <= jtd_pkg::IR_CAPTURE;
		else if (rise && state == jtd_pkg::JTD_SIR) ir_sh <= {tdi, ir_sh[3:1]};
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) instr_o <= jtd_pkg::IR_IDLE_DEFAULT;
		else if (state == jtd_pkg::JTD_TLR) instr_o <= jtd_pkg::IR_IDLE_DEFAULT;
		else if (rise && state == jtd_pkg::JTD_UIR) instr_o <= ir_sh;
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dr_sh <= 8'h00;
			byp   <= 1'b0;
		end else if (rise && state == jtd_pkg::JTD_CDR) begin
			dr_sh <= (instr_o == jtd_pkg::IR_BRKCFG) ? {5'h00, brk_mode_o}
				: dr_capture_i;
			byp   <= 1'b0;
		end else if (rise && state == jtd_pkg::JTD_SDR) begin
			dr_sh <= {tdi, dr_sh[7:1]};
			byp   <= tdi;
		end
	end
	// update-dr latches
	// break config and cpu-chain data only reachable with debug on
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dr_update_o <= 8'h00;
			brk_mode_o  <= 3'h0;
		end else if (rise && state == jtd_pkg::JTD_UDR) begin
			// reset register is board-level, not behind the debug gate
			if ((instr_o == jtd_pkg::IR_DATA && debug_enabled_o)
				|| instr_o == jtd_pkg::IR_RESET)
				dr_update_o <= dr_sh;
			if (instr_o == jtd_pkg::IR_BRKCFG && debug_enabled_o
				&& dr_sh[2:0] < 3'(jtd_pkg::BRK_MODES))
				brk_mode_o <= dr_sh[2:0];
		end
	end
	// ==========================================================
	// path select, tdo on fall
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			port.tdo    <= 1'b0;
			port.tdo_oe <= 1'b0;
		end else if (fall) begin
			port.tdo_oe <= state == jtd_pkg::JTD_SIR || state == jtd_pkg::JTD_SDR;
			if (state == jtd_pkg::JTD_SIR) port.tdo <= ir_sh[0];
			else if (instr_o == jtd_pkg::IR_BYPASS) port.tdo <= byp;
			else port.tdo <= dr_sh[0];
		end
	end
	// ==========================================================
	// idle action, reset pull
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idle_action_o     <= 1'b0;
			port.rst_pull_dev <= 1'b0;
			sys_reset_seen_o  <= 1'b0;
		end else begin
			idle_action_o <= state == jtd_pkg::JTD_RTI
				&& instr_o == jtd_pkg::IR_DATA;
			port.rst_pull_dev <= instr_o == jtd_pkg::IR_RESET
				&& dr_update_o[0];
			sys_reset_seen_o  <= !pins[0];
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tap_enabled_o   <= 1'b0;
			pin_pullup_o    <= 1'b0;
			debug_enabled_o <= 1'b0;
		end else begin
			tap_enabled_o   <= en;
			pin_pullup_o    <= en;
			debug_enabled_o <= en && debug_system_enable_fuse_i
				&& !security_lock_bit_one_i && !security_lock_bit_two_i;
		end
	end
endmodule : jtd_device

// file: jtd_host.sv
`timescale 1ns/1ps
// host end: software-driven scan controller
module jtd_host (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	jtd_if.host             port,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic [7:0]      rdata_o
);
	typedef enum logic [2:0] {
		JTDH_IDLE = 3'b001, JTDH_WALK = 3'b010, JTDH_DONE = 3'b100
	} jtdh_e;
	jtdh_e      st;
	logic [7:0] data;
	logic [7:0] result;
	logic [3:0] len;
	logic [3:0] nbits;  // bits captured from tdo in this walk
	logic [31:0] tms_seq;  // tms per rise, lsb first
	logic [5:0] steps;
	logic [5:0] cnt;
	logic [5:0] shift_lo;
	logic [2:0] div;
	logic       tdo_s;
	logic       rst_s;
	jtd_sync #(.W(2)) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({port.tdo, port.rst_line}),
		.q_o     ({tdo_s, rst_s})
	);
	logic half;
	assign half = div == 3'(jtd_pkg::TCK_HALF - 1);
	// ==========================================================
	// tck divider, runs only while walking
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) div <= 3'h0;
		else if (st != JTDH_WALK || half) div <= 3'h0;
		else div <= div + 3'h1;
	end
	// ==========================================================
	// sequences
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= JTDH_IDLE;
			tms_seq <= 32'h0;
			steps <= 6'h0;
			cnt <= 6'h0;
			shift_lo <= 6'h0;
			nbits <= 4'h0;
			port.tck <= 1'b0;
			port.tms <= 1'b1;
			port.tdi <= 1'b0;
			result <= 8'h00;
		end else case (st)
			JTDH_IDLE: begin
				cnt <= 6'h0;
				if (wr_i && addr_i == jtd_pkg::ADR_CMD) begin
					st <= JTDH_WALK;
					// tms for the first rise goes out now, the rest at falls
					if (wdata_i[3:0] == jtd_pkg::CMD_IR) begin
						// 1,1,0,0 then 4 bits (last high) then 1,0
						tms_seq <= 32'h0000_0183;
						steps <= 6'd10;
						shift_lo <= 6'd4;
						nbits <= 4'd4;
						port.tms <= 1'b1;
					end else if (wdata_i[3:0] == jtd_pkg::CMD_DR) begin
						nbits <= len;
						port.tms <= 1'b1;
						// 1,0,0 then len bits (last high) then 1,0
						tms_seq <= (32'h1 | (32'h1 << (len + 4'h2))
							| (32'h1 << (len + 4'h3)));
						steps <= 6'(len) + 6'd5;
						shift_lo <= 6'd3;
					end else if (wdata_i[3:0] == jtd_pkg::CMD_RESET) begin
						tms_seq <= 32'h0000_001F;
						steps <= 6'(jtd_pkg::RESET_TLR_CLOCKS) + 6'd1;
						shift_lo <= 6'd63;
						nbits <= 4'h0;
						port.tms <= 1'b1;
					end else begin
						tms_seq <= 32'h0;
						steps <= 6'd1;
						shift_lo <= 6'd63;
						nbits <= 4'h0;
						port.tms <= 1'b0;
					end
				end
			end
			JTDH_WALK: if (half) begin
				port.tck <= !port.tck;
				if (port.tck) begin
					// falling edge: set up next tms and tdi
					if (cnt == steps) st <= JTDH_DONE;
					port.tms <= tms_seq[cnt[4:0]];
					if (cnt >= shift_lo) port.tdi <= data[3'(cnt - shift_lo)];
					// tdo for the last rise has crossed both synchronisers
					// only by now; sampling at the rise would lag one bit
					if (cnt > shift_lo && cnt <= shift_lo + 6'(nbits))
						result <= {tdo_s, result[7:1]};
				end else begin
					// rising edge: device samples
					cnt <= cnt + 6'h1;
				end
			end
			default: st <= JTDH_IDLE;
		endcase
	end
	// ==========================================================
	// registers and reset pull
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data <= 8'h00;
			len <= 4'h8;
			port.rst_pull_dbg <= 1'b0;
		end else if (wr_i && addr_i == jtd_pkg::ADR_DATA) data <= wdata_i;
		else if (wr_i && addr_i == jtd_pkg::ADR_LEN) len <= wdata_i[3:0];
		else if (wr_i && addr_i == jtd_pkg::ADR_STATUS)
			port.rst_pull_dbg <= wdata_i[1];
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) rdata_o <= 8'h00;
		else if (rd_i && addr_i == jtd_pkg::ADR_RESULT) rdata_o <= result;
		else if (rd_i && addr_i == jtd_pkg::ADR_DATA) rdata_o <= data;
		else if (rd_i && addr_i == jtd_pkg::ADR_LEN) rdata_o <= {4'h0, len};
		else if (rd_i && addr_i == jtd_pkg::ADR_STATUS)
			rdata_o <= {5'h00, !rst_s, port.rst_pull_dbg, st != JTDH_IDLE};
		else rdata_o <= 8'h00;
	end
endmodule : jtd_host

// file: jtd_checker.sv
`timescale 1ns/1ps
// watches the test-port wires between the two ends
module jtd_checker (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic rst_pull_dbg,
	input wire logic rst_line
);
	logic       tck_q;
	logic [4:0] still;
	// ==========================================================
	// cycles since tck last moved, saturating
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tck_q <= 1'b0;
			still <= 5'h00;
		end else begin
			tck_q <= tck;
			if (tck != tck_q) still <= 5'h00;
			else if (still != 5'h1F) still <= still + 5'h01;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================================
	// link clock shape and the lines qualified by it
	tck_high_a: assert property (
		$rose(tck) |=> tck [*3] ##1 !tck)
		else $error("tck high phase not four cycles");
	tck_low_a: assert property (
		$fell(tck) |=> !tck [*3])
		else $error("tck low phase too short");
	tms_hold_a: assert property (
		tck && $past(tck) |-> $stable(tms))
		else $error("tms moved while tck high");
	tdi_hold_a: assert property (
		tck && $past(tck) |-> $stable(tdi))
		else $error("tdi moved while tck high");
	// device output moves only in the low phase
	tdo_fall_a: assert property (
		$changed(tdo) |-> !tck)
		else $error("tdo moved while tck high");
	oe_fall_a: assert property (
		$changed(tdo_oe) |-> !tck)
		else $error("tdo enable moved while tck high");
	oe_idle_a: assert property (
		still == 5'h1F |-> !tdo_oe)
		else $error("tdo driven outside a shift");
	reset_pull_a: assert property (
		rst_pull_dbg |-> !rst_line)
		else $error("reset line high while pulled");
endmodule : jtd_checker

// file: jtd_tb.sv
`timescale 1ns/1ps
module jtd_tb;
	logic        clk_i, rst_n_i, wr, rd, fuse, dis, ocd, lk1, lk2;
	logic        tap_en, pull_up, dbg_en, idle_act, rst_seen;
	logic [3:0]  addr, instr;
	logic [7:0]  wdata, rdata, cap, res, dr_upd, d;
	logic [2:0]  brk;
	logic [31:0] seed;
	int          n_errors, n_compared, len;
	jtd_if i_jtd_if ();
	jtd_device i_jtd_device (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.port(i_jtd_if), .test_port_enable_fuse_i(fuse),
		.test_port_disable_bit_i(dis), .debug_system_enable_fuse_i(ocd),
		.security_lock_bit_one_i(lk1), .security_lock_bit_two_i(lk2),
		.dr_capture_i(cap), .tap_enabled_o(tap_en),
		.pin_pullup_o(pull_up), .debug_enabled_o(dbg_en),
		.instr_o(instr), .dr_update_o(dr_upd), .brk_mode_o(brk),
		.idle_action_o(idle_act), .sys_reset_seen_o(rst_seen));
	jtd_host i_jtd_host (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.port(i_jtd_if), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata));
	jtd_checker i_jtd_checker (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.tck(i_jtd_if.tck), .tms(i_jtd_if.tms), .tdi(i_jtd_if.tdi),
		.tdo(i_jtd_if.tdo), .tdo_oe(i_jtd_if.tdo_oe),
		.rst_pull_dbg(i_jtd_if.rst_pull_dbg),
		.rst_line(i_jtd_if.rst_line));
	// ==========================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	// low len bits of a byte, the part a short scan moves
	function automatic logic [7:0] fit(input logic [7:0] v, input int n);
		return v & (8'hFF >> (8 - n));
	endfunction : fit
	task automatic chk(input string nm, input logic [7:0] got,
		input logic [7:0] ex);
		n_compared++;
		if (got !== ex) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task automatic test_done;
		if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done
	// gap cycle between strobes keeps one assignment per step
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_i);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_i);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	task automatic run(input logic [3:0] c);
		logic [7:0] st;
		wr_reg(jtd_pkg::ADR_CMD, {4'h0, c});
		for (int i = 0; i < 300; i++) begin
			rd_reg(jtd_pkg::ADR_STATUS, st);
			if (st[0] === 1'b0) begin
				rd_reg(jtd_pkg::ADR_RESULT, res);
				return;
			end
		end
		n_errors++;
		test_done();
	endtask : run
	task automatic ir(input logic [3:0] c);
		wr_reg(jtd_pkg::ADR_DATA, {4'h0, c});
		run(jtd_pkg::CMD_IR);
		chk("ir capture", {4'h0, res[7:4]}, 8'h01);
		chk("instr", {4'h0, instr}, {4'h0, c});
	endtask : ir
	task automatic dr(input int n, input logic [7:0] v);
		wr_reg(jtd_pkg::ADR_LEN, 8'(n));
		wr_reg(jtd_pkg::ADR_DATA, v);
		run(jtd_pkg::CMD_DR);
	endtask : dr
	// level inputs pass a register or the pin synchroniser before they show
	task automatic settle;
		repeat (8) @(posedge clk_i);
	endtask : settle
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	// ==========================================================
	// main sequence
	initial begin
		{rst_n_i, wr, rd, dis, lk1, lk2, addr, wdata} = '0;
		{fuse, ocd} = 2'b11;
		cap = 8'h00;
		seed = 32'd33;
		n_errors = 0;
		n_compared = 0;
		repeat (10) @(posedge clk_i);
		chk("reset instr", {4'h0, instr}, 8'h0F);
		rst_n_i <= 1'b1;
		settle();
		chk("enabled", {6'h00, tap_en, pull_up}, 8'h03);
		chk("debug on", {7'h00, dbg_en}, 8'h01);
		run(jtd_pkg::CMD_IDLE);
		chk("idle bypass", {7'h00, idle_act}, 8'h00);
		d = 8'hA5;
		dr(8, d);
		chk("bypass path", res, {d[6:0], 1'b0});
		ir(jtd_pkg::IR_DATA);
		chk("idle data", {7'h00, idle_act}, 8'h01);
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			cap <= seed[7:0];
			d = seed[15:8];
			len = (i == 0) ? 1 : (i == 1) ? 8 : int'(seed[18:16]) + 1;
			dr(len, d);
			chk("dr out", res >> (8 - len), fit(cap, len));
			if (len == 8) chk("dr update", dr_upd, d);
		end
		ir(jtd_pkg::IR_BRKCFG);
		for (int m = 0; m < 6; m++) begin
			dr(8, 8'(m));
			chk("brk mode", {5'h00, brk}, 8'((m < 5) ? m : 4));
		end
		// each lock, and a blank debug fuse, shuts debug
		for (int k = 0; k < 3; k++) begin
			{lk1, lk2, ocd} <= (k == 0) ? 3'b101 : (k == 1) ? 3'b011 : 3'b000;
			settle();
			chk("debug off", {7'h00, dbg_en}, 8'h00);
			dr(8, 8'h01);
			chk("brk kept", {5'h00, brk}, 8'h04);
		end
		{lk1, lk2, ocd} <= 3'b001;
		ir(jtd_pkg::IR_RESET);
		dr(8, 8'h01);
		chk("dev pull", {6'h00, i_jtd_if.rst_line, rst_seen}, 8'h01);
		dr(8, 8'h00);
		wr_reg(jtd_pkg::ADR_STATUS, 8'h02);
		settle();
		chk("dbg pull", {6'h00, i_jtd_if.rst_line, rst_seen}, 8'h01);
		wr_reg(jtd_pkg::ADR_STATUS, 8'h00);
		settle();
		chk("released", {6'h00, i_jtd_if.rst_line, rst_seen}, 8'h02);
		ir(jtd_pkg::IR_DATA);
		fuse <= 1'b0;
		settle();
		chk("fuse off", {3'h0, tap_en, pull_up, instr[2:0]}, 8'h07);
		fuse <= 1'b1;
		settle();
		run(jtd_pkg::CMD_IDLE);
		ir(jtd_pkg::IR_DATA);
		run(jtd_pkg::CMD_RESET);
		chk("tms reset", {4'h0, instr}, 8'h0F);
		dis <= 1'b1;
		settle();
		chk("disabled", {6'h00, tap_en, pull_up}, 8'h00);
		test_done();
	end
endmodule : jtd_tb
